// [hw/pmc_pkg.sv]
package pmc_pkg;

  // ==========================================================================
  // power modes
  typedef enum logic [2:0] {
    PMC_NORMAL,
    PMC_IDLE,
    PMC_SUSPEND,
    PMC_SNOOZE,
    PMC_STOP,
    PMC_SHUTDOWN
  } pmc_mode_t;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_PERIPH = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================================
  // reset values of registered outputs
  localparam logic RST_CORE_CLK_EN = 1'h1;
  localparam logic RST_FAST_OSC_EN = 1'h1;
  localparam logic RST_POWER_NETS_ON = 1'h1;
  localparam logic RST_PIN_HOLD = 1'h0;
  localparam logic RST_REG_LOW_BIAS = 1'h0;
  localparam logic RST_REG_POWER_DOWN = 1'h0;
  localparam logic RST_SLOW_TIMER_EN = 1'h0;
  localparam logic RST_CORE_RESET = 1'h0;
  localparam logic [NUM_PERIPH-1:0] RST_PERIPH_CLK_EN = 8'h00;
  // synchroniser idle levels: reset pin released, comparator high
  localparam logic [SYNC_STAGES-1:0] RST_PIN_SYNC = 2'h3;
  localparam logic [SYNC_STAGES-1:0] RST_CMP_SYNC = 2'h3;

endpackage : pmc_pkg

// [hw/pmc_power_mode_controller.sv]
`timescale 1ns/10ps

module pmc_power_mode_controller (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // mode requests from the power control bits
  input wire logic idle_req_i,
  input wire logic suspend_req_i,
  input wire logic snooze_req_i,
  input wire logic stop_req_i,
  input wire logic regulator_off_select_i,
  // wake sources
  input wire logic irq_any_i,
  input wire logic timer4_event_i,
  input wire logic serial_periph_port_wake_i,
  input wire logic two_wire_port_wake_i,
  input wire logic port_match_i,
  input wire logic comparator0_i,
  input wire logic config_logic_unit_irq_i,
  input wire logic config_logic_unit_irq_en_i,
  // reset sources
  input wire logic reset_pin_n_i,
  input wire logic por_i,
  input wire logic other_reset_i,
  // peripheral usage
  input wire logic [pmc_pkg::NUM_PERIPH-1:0] periph_in_use_i,
  // clock, oscillator and supply controls
  output logic core_clk_en_o,
  output logic [pmc_pkg::NUM_PERIPH-1:0] periph_clk_en_o,
  output logic fast_osc_low_en_o,
  output logic fast_osc_high_en_o,
  output logic slow_timer_clk_en_o,
  output logic reg_low_bias_o,
  output logic reg_power_down_o,
  output logic power_nets_on_o,
  output logic pin_hold_o,
  // status
  output logic core_reset_o,
  output pmc_pkg::pmc_mode_t mode_o
);

  // ==========================================================================
  // decoders
  function automatic logic is_clocked(input pmc_pkg::pmc_mode_t m);
    is_clocked = (m == pmc_pkg::PMC_NORMAL) || (m == pmc_pkg::PMC_IDLE);
  endfunction : is_clocked

  function automatic logic is_sleep(input pmc_pkg::pmc_mode_t m);
    is_sleep = (m == pmc_pkg::PMC_SUSPEND) || (m == pmc_pkg::PMC_SNOOZE);
  endfunction : is_sleep

  function automatic logic is_off(input pmc_pkg::pmc_mode_t m);
    is_off = (m == pmc_pkg::PMC_STOP) || (m == pmc_pkg::PMC_SHUTDOWN);
  endfunction : is_off

  // ==========================================================================
  // synchronisers for pin-level inputs
  logic [pmc_pkg::SYNC_STAGES-1:0] pin_sync;
  logic [pmc_pkg::SYNC_STAGES-1:0] cmp_sync;
  logic cmp_prev;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_sync <= pmc_pkg::RST_PIN_SYNC;
      cmp_sync <= pmc_pkg::RST_CMP_SYNC;
      cmp_prev <= pmc_pkg::RST_CMP_SYNC[pmc_pkg::SYNC_STAGES-1];
    end else begin
      pin_sync <= {pin_sync[0], reset_pin_n_i};
      cmp_sync <= {cmp_sync[0], comparator0_i};
      cmp_prev <= cmp_sync[1];
    end
  end

  logic pin_reset;
  logic cmp_fall;
  logic sleep_wake;
  logic hard_reset;
  assign pin_reset = !pin_sync[1];
  assign cmp_fall = cmp_prev && !cmp_sync[1];
  // logic-unit interrupt only counts when enabled
  assign sleep_wake = timer4_event_i || serial_periph_port_wake_i || two_wire_port_wake_i ||
                      port_match_i || cmp_fall ||
                      (config_logic_unit_irq_i && config_logic_unit_irq_en_i);
  assign hard_reset = pin_reset || por_i;

  // ==========================================================================
  // mode state machine
  pmc_pkg::pmc_mode_t state;
  pmc_pkg::pmc_mode_t next_state;
  logic next_core_reset;

  always_comb begin
    next_state = state;
    next_core_reset = 1'h0;
    unique case (state)
      pmc_pkg::PMC_NORMAL: begin
        // stop wins over the lighter modes if software sets several at once
        if (stop_req_i) begin
          next_state = regulator_off_select_i ? pmc_pkg::PMC_SHUTDOWN
                                              : pmc_pkg::PMC_STOP;
        end else if (snooze_req_i) begin
          next_state = pmc_pkg::PMC_SNOOZE;
        end else if (suspend_req_i) begin
          next_state = pmc_pkg::PMC_SUSPEND;
        end else if (idle_req_i) begin
          next_state = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (irq_any_i) begin
          next_state = pmc_pkg::PMC_NORMAL;
        end
      end
      pmc_pkg::PMC_SUSPEND, pmc_pkg::PMC_SNOOZE: begin
        if (sleep_wake) begin
          next_state = pmc_pkg::PMC_NORMAL;
        end
      end
      pmc_pkg::PMC_STOP: begin
        if (hard_reset || other_reset_i) begin
          next_state = pmc_pkg::PMC_NORMAL;
          next_core_reset = 1'h1;
        end
      end
      pmc_pkg::PMC_SHUTDOWN: begin
        // internal reset sources are dead here, so only the pin or power-on count
        if (hard_reset) begin
          next_state = pmc_pkg::PMC_NORMAL;
          next_core_reset = 1'h1;
        end
      end
      default: begin
        next_state = pmc_pkg::PMC_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= pmc_pkg::PMC_NORMAL;
      core_reset_o <= pmc_pkg::RST_CORE_RESET;
    end else begin
      state <= next_state;
      core_reset_o <= next_core_reset;
    end
  end

  // ==========================================================================
  // clock and supply controls, registered from the next mode so they track state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_o <= pmc_pkg::PMC_NORMAL;
      core_clk_en_o <= pmc_pkg::RST_CORE_CLK_EN;
      fast_osc_low_en_o <= pmc_pkg::RST_FAST_OSC_EN;
      fast_osc_high_en_o <= pmc_pkg::RST_FAST_OSC_EN;
      slow_timer_clk_en_o <= pmc_pkg::RST_SLOW_TIMER_EN;
      reg_low_bias_o <= pmc_pkg::RST_REG_LOW_BIAS;
      reg_power_down_o <= pmc_pkg::RST_REG_POWER_DOWN;
      power_nets_on_o <= pmc_pkg::RST_POWER_NETS_ON;
      pin_hold_o <= pmc_pkg::RST_PIN_HOLD;
    end else begin
      mode_o <= next_state;
      core_clk_en_o <= (next_state == pmc_pkg::PMC_NORMAL);
      fast_osc_low_en_o <= is_clocked(next_state);
      fast_osc_high_en_o <= is_clocked(next_state);
      slow_timer_clk_en_o <= is_sleep(next_state);
      reg_low_bias_o <= (next_state == pmc_pkg::PMC_SNOOZE);
      reg_power_down_o <= (next_state == pmc_pkg::PMC_SHUTDOWN);
      power_nets_on_o <= !is_off(next_state);
      pin_hold_o <= is_off(next_state);
    end
  end

  // per-peripheral gating; an unused block costs only leakage
  genvar gi;
  generate
    for (gi = 0; gi < pmc_pkg::NUM_PERIPH; gi++) begin : g_periph
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          periph_clk_en_o[gi] <= pmc_pkg::RST_PERIPH_CLK_EN[gi];
        end else begin
          periph_clk_en_o[gi] <= periph_in_use_i[gi] && is_clocked(next_state);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // checks
  // the first edge after reset release still shows the reset value of the gates
  normal_clocks_on_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($past(resetn_i) && (mode_o == pmc_pkg::PMC_NORMAL)) |->
      core_clk_en_o && fast_osc_low_en_o && power_nets_on_o &&
      (periph_clk_en_o == $past(periph_in_use_i)))
    else $error("normal mode lost a clock");

  idle_entry_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_o == pmc_pkg::PMC_NORMAL && idle_req_i && !stop_req_i && !snooze_req_i &&
     !suspend_req_i) |=> !core_clk_en_o && fast_osc_low_en_o &&
      (periph_clk_en_o == $past(periph_in_use_i)))
    else $error("idle did not halt only the core");

  wake_no_reset_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    ((mode_o == pmc_pkg::PMC_IDLE && irq_any_i) ||
     (is_sleep(mode_o) && sleep_wake)) |=> core_clk_en_o && !core_reset_o)
    else $error("wake did not resume cleanly");

  suspend_stops_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_o == pmc_pkg::PMC_SUSPEND) |->
      !core_clk_en_o && (periph_clk_en_o == '0) && !fast_osc_low_en_o &&
      !fast_osc_high_en_o && !reg_low_bias_o && power_nets_on_o)
    else $error("suspend controls wrong");

  snooze_bias_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(mode_o == pmc_pkg::PMC_SNOOZE) |->
      reg_low_bias_o && !fast_osc_high_en_o && !core_clk_en_o && $past(snooze_req_i))
    else $error("snooze bias not lowered");

  slow_timer_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    slow_timer_clk_en_o == is_sleep(mode_o))
    else $error("slow timer clock wrong");

  sleep_wake_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    (is_sleep(mode_o) && !sleep_wake) |=> is_sleep(mode_o) ##0 $stable(mode_o))
    else $error("sleep left without wake source");

  stop_exit_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_o == pmc_pkg::PMC_STOP && other_reset_i) |=>
      core_reset_o && power_nets_on_o && !pin_hold_o ##1 !core_reset_o)
    else $error("stop did not exit on reset");

  shutdown_hold_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_o == pmc_pkg::PMC_SHUTDOWN && !pin_reset && !por_i) |=>
      mode_o == pmc_pkg::PMC_SHUTDOWN && reg_power_down_o && pin_hold_o)
    else $error("shutdown left without pin or power-on reset");

  periph_gate_a:
  assert property (@(posedge clk_i) disable iff (!resetn_i)
    (periph_clk_en_o & ~$past(periph_in_use_i)) == '0)
    else $error("unused peripheral clocked");

endmodule : pmc_power_mode_controller

// [dv/test_power_mode_controller.sv]
`timescale 1ns/10ps
module test_power_mode_controller;
  // ==========================================================================
  // stimulus and observation
  logic clk_i = 1'h0;
  logic resetn_i, idle_req_i, suspend_req_i, snooze_req_i, stop_req_i, regulator_off_select_i;
  logic irq_any_i, timer4_event_i, serial_periph_port_wake_i, two_wire_port_wake_i;
  logic port_match_i, comparator0_i, config_logic_unit_irq_i, config_logic_unit_irq_en_i;
  logic reset_pin_n_i, por_i, other_reset_i;
  logic [7:0] periph_in_use_i;
  logic core_clk_en_o, fast_osc_low_en_o, fast_osc_high_en_o, slow_timer_clk_en_o;
  logic reg_low_bias_o, reg_power_down_o, power_nets_on_o, pin_hold_o, core_reset_o;
  logic [7:0] periph_clk_en_o;
  pmc_pkg::pmc_mode_t mode_o;
  int errors, n_tests, cycles;
  // all single-bit clock, oscillator and supply controls in one vector keeps each state check to one line
  wire logic [7:0] ctl = {core_clk_en_o, fast_osc_low_en_o, fast_osc_high_en_o,
    slow_timer_clk_en_o, reg_low_bias_o, reg_power_down_o, power_nets_on_o, pin_hold_o};

  pmc_power_mode_controller dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .idle_req_i(idle_req_i),
    .suspend_req_i(suspend_req_i), .snooze_req_i(snooze_req_i), .stop_req_i(stop_req_i),
    .regulator_off_select_i(regulator_off_select_i), .irq_any_i(irq_any_i),
    .timer4_event_i(timer4_event_i), .serial_periph_port_wake_i(serial_periph_port_wake_i),
    .two_wire_port_wake_i(two_wire_port_wake_i), .port_match_i(port_match_i),
    .comparator0_i(comparator0_i), .config_logic_unit_irq_i(config_logic_unit_irq_i),
    .config_logic_unit_irq_en_i(config_logic_unit_irq_en_i), .reset_pin_n_i(reset_pin_n_i),
    .por_i(por_i), .other_reset_i(other_reset_i), .periph_in_use_i(periph_in_use_i),
    .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .fast_osc_low_en_o(fast_osc_low_en_o), .fast_osc_high_en_o(fast_osc_high_en_o),
    .slow_timer_clk_en_o(slow_timer_clk_en_o), .reg_low_bias_o(reg_low_bias_o),
    .reg_power_down_o(reg_power_down_o), .power_nets_on_o(power_nets_on_o),
    .pin_hold_o(pin_hold_o), .core_reset_o(core_reset_o), .mode_o(mode_o));

  always #4 clk_i = ~clk_i;

  // ==========================================================================
  // comparisons and closing
  task automatic chk_vec(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk_vec

  task automatic chk_mode(input pmc_pkg::pmc_mode_t exp);
    chk_vec("mode", {5'h00, exp}, {5'h00, mode_o});
  endtask : chk_mode

  task automatic final_report;
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  // the whole run is under a hundred cycles, so this only cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic wait_normal(input int lim);
    int i;
    i = 0;
    while (mode_o !== pmc_pkg::PMC_NORMAL && i < lim) begin
      @(negedge clk_i);
      i++;
    end
  endtask : wait_normal

  task automatic idle_test;
    periph_in_use_i = 8'h3C;
    idle_req_i = 1'h1;
    @(negedge clk_i);
    idle_req_i = 1'h0;
    chk_mode(pmc_pkg::PMC_IDLE);
    chk_vec("controls", 8'h62, ctl);
    chk_vec("periph clocks", 8'h3C, periph_clk_en_o);
    stop_req_i = 1'h1;
    timer4_event_i = 1'h1;
    @(negedge clk_i);
    stop_req_i = 1'h0;
    timer4_event_i = 1'h0;
    chk_mode(pmc_pkg::PMC_IDLE);
    irq_any_i = 1'h1;
    @(negedge clk_i);
    irq_any_i = 1'h0;
    chk_mode(pmc_pkg::PMC_NORMAL);
    chk_vec("core reset", 8'h00, {7'h00, core_reset_o});
  endtask : idle_test

  task automatic sleep_test(input logic snz, input int src);
    suspend_req_i = ~snz;
    snooze_req_i = snz;
    @(negedge clk_i);
    suspend_req_i = 1'h0;
    snooze_req_i = 1'h0;
    chk_mode(snz ? pmc_pkg::PMC_SNOOZE : pmc_pkg::PMC_SUSPEND);
    chk_vec("controls", snz ? 8'h1A : 8'h12, ctl);
    chk_vec("periph clocks", 8'h00, periph_clk_en_o);
    irq_any_i = 1'h1;
    config_logic_unit_irq_i = 1'h1;
    repeat (2) @(negedge clk_i);
    irq_any_i = 1'h0;
    config_logic_unit_irq_i = 1'h0;
    chk_mode(snz ? pmc_pkg::PMC_SNOOZE : pmc_pkg::PMC_SUSPEND);
    case (src)
      0: timer4_event_i = 1'h1;
      1: serial_periph_port_wake_i = 1'h1;
      2: two_wire_port_wake_i = 1'h1;
      3: port_match_i = 1'h1;
      4: {config_logic_unit_irq_i, config_logic_unit_irq_en_i} = 2'h3;
      default: comparator0_i = 1'h0;
    endcase
    wait_normal(6);
    {timer4_event_i, serial_periph_port_wake_i, two_wire_port_wake_i, port_match_i} = 4'h0;
    {config_logic_unit_irq_i, config_logic_unit_irq_en_i} = 2'h0;
    comparator0_i = 1'h1;
    chk_mode(pmc_pkg::PMC_NORMAL);
    chk_vec("controls", 8'hE2, ctl);
    chk_vec("core reset", 8'h00, {7'h00, core_reset_o});
  endtask : sleep_test

  task automatic deep_test(input logic sel, input int kind);
    @(negedge clk_i);
    stop_req_i = 1'h1;
    regulator_off_select_i = sel;
    @(negedge clk_i);
    stop_req_i = 1'h0;
    chk_mode(sel ? pmc_pkg::PMC_SHUTDOWN : pmc_pkg::PMC_STOP);
    chk_vec("controls", sel ? 8'h05 : 8'h01, ctl);
    if (kind == 0 && sel) begin
      other_reset_i = 1'h1;
      repeat (4) @(negedge clk_i);
      other_reset_i = 1'h0;
      chk_mode(pmc_pkg::PMC_SHUTDOWN);
      kind = 1;
    end
    case (kind)
      0: other_reset_i = 1'h1;
      1: por_i = 1'h1;
      default: reset_pin_n_i = 1'h0;
    endcase
    wait_normal(6);
    {other_reset_i, por_i, reset_pin_n_i} = 3'h1;
    chk_mode(pmc_pkg::PMC_NORMAL);
    chk_vec("core reset", 8'h01, {7'h00, core_reset_o});
    chk_vec("controls", 8'hE2, ctl);
    @(negedge clk_i);
    chk_vec("core reset", 8'h00, {7'h00, core_reset_o});
  endtask : deep_test

  initial begin
    errors = 0;
    n_tests = 0;
    cycles = 0;
    {idle_req_i, suspend_req_i, snooze_req_i, stop_req_i, regulator_off_select_i} = 5'h00;
    {irq_any_i, timer4_event_i, serial_periph_port_wake_i, two_wire_port_wake_i} = 4'h0;
    {port_match_i, config_logic_unit_irq_i, config_logic_unit_irq_en_i} = 3'h0;
    {por_i, other_reset_i} = 2'h0;
    {reset_pin_n_i, comparator0_i} = 2'h3;
    periph_in_use_i = 8'hA5;
    resetn_i = 1'h0;
    repeat (10) @(negedge clk_i);
    resetn_i = 1'h1;
    @(negedge clk_i);
    chk_mode(pmc_pkg::PMC_NORMAL);
    chk_vec("controls", 8'hE2, ctl);
    chk_vec("periph clocks", 8'hA5, periph_clk_en_o);
    idle_test();
    for (int m = 0; m < 2; m++) for (int s = 0; s < 6; s++) sleep_test(m[0], s);
    deep_test(1'h0, 0);
    deep_test(1'h0, 1);
    deep_test(1'h0, 2);
    deep_test(1'h1, 0);
    deep_test(1'h1, 2);
    final_report();
  end
endmodule : test_power_mode_controller
